// ===== hdl/eie_pkg.sv
// Shared constants, types and register map of the extended instruction executor
package eie_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int PWORD_W = 16;
    localparam int DMEM_AW = 8;
    localparam int PMEM_AW = 12;
    localparam int ADR_W = 8;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_WORK = 8'h08;
    localparam logic [7:0] OFS_FLAGS = 8'h0C;
    localparam logic [7:0] OFS_TPL = 8'h10;
    localparam logic [7:0] OFS_TPH = 8'h14;
    localparam logic [7:0] OFS_TLATCH = 8'h18;
    localparam logic [7:0] OFS_DADDR = 8'h1C;
    localparam logic [7:0] OFS_DDATA = 8'h20;
    localparam logic [7:0] OFS_PADDR = 8'h24;
    localparam logic [7:0] OFS_PDATA = 8'h28;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ADDR_LSB = 4;
    localparam int CMD_BIT_LSB = 12;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_SKIP_BIT = 1;
    localparam int STAT_CYC_LSB = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic [7:0] TP_RST = 8'h00;
    localparam logic [11:0] PADDR_RST = 12'h000;

    // ------------------------------------------------------------
    // Timing counts in instruction cycles
    // ------------------------------------------------------------
    localparam logic [1:0] PLAIN_CYCLES = 2'h1;
    localparam logic [1:0] TABLE_CYCLES = 2'h2;
    localparam logic [1:0] SKIP_CYCLES = 2'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_SUBTRACT_INTO_MEMORY = 4'h0,
        OP_NIBBLE_EXCHANGE_INPLACE = 4'h1,
        OP_NIBBLE_EXCHANGE_TO_WORKING = 4'h2,
        OP_SKIP_WHEN_NULL = 4'h3,
        OP_SKIP_WHEN_NULL_WITH_MOVE = 4'h4,
        OP_SKIP_WHEN_BIT_CLEAR = 4'h5,
        OP_PAGED_TABLE_FETCH = 4'h6,
        OP_FINAL_PAGE_TABLE_FETCH = 4'h7,
        OP_PREINC_PAGED_TABLE_FETCH = 4'h8,
        OP_PREINC_FINAL_PAGE_TABLE_FETCH = 4'h9,
        OP_EXCLUSIVE_OR_TO_WORKING = 4'hA,
        OP_EXCLUSIVE_OR_TO_MEMORY = 4'hB
    } eie_op_t;

    typedef struct packed {
        logic [2:0] bitSel;
        logic [7:0] addr;
        eie_op_t op;
    } eie_cmd_t;

    typedef struct packed {
        logic carryZero;
        logic signedCarry;
        logic signedRange;
        logic zero;
        logic lowerNibbleCarry;
        logic carry;
    } eie_flags_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } eie_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } eie_wb_rsp_t;

endpackage : eie_pkg

// ===== hdl/eie_alu.sv
// Combinational datapath: subtract with flags, nibble exchange, exclusive or
module eie_alu (
    // Operands
    input wire logic [7:0] working,
    input wire logic [7:0] memByte,
    // Results
    output logic [7:0] diff,
    output eie_pkg::eie_flags_t subFlags,
    output logic [7:0] xorVal,
    output logic [7:0] swapVal
);
    import eie_pkg::*;

    logic [8:0] wide;
    logic [4:0] lowWide;

    assign wide = {1'b0, working} - {1'b0, memByte};
    assign lowWide = {1'b0, working[3:0]} - {1'b0, memByte[3:0]};
    assign diff = wide[7:0];
    // Borrow out means negative, so carry is its inverse
    assign subFlags.carry = ~wide[8];
    assign subFlags.lowerNibbleCarry = ~lowWide[4];
    assign subFlags.zero = (wide[7:0] == 8'h00);
    assign subFlags.signedRange = (working[7] ^ memByte[7]) & (wide[7] ^ working[7]);
    // True sign of the result despite overflow
    assign subFlags.signedCarry = subFlags.signedRange ^ wide[7];
    assign subFlags.carryZero = (wide[7:0] == 8'h00);
    assign xorVal = working ^ memByte;
    assign swapVal = {memByte[3:0], memByte[7:4]};

endmodule : eie_alu

// ===== hdl/eie_prog_mem.sv
// Program word store with one write port and two read ports
module eie_prog_mem #(
    parameter int AW = 12,
    parameter int DW = 16
) (
    // Clock
    input wire logic clock,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] wa,
    input wire logic [DW-1:0] wd,
    // Read ports
    input wire logic [AW-1:0] raA,
    output logic [DW-1:0] rdA,
    input wire logic [AW-1:0] raB,
    output logic [DW-1:0] rdB
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[wa] <= wd;
        end
    end

    assign rdA = mem[raA];
    assign rdB = mem[raB];

endmodule : eie_prog_mem

// ===== hdl/eie_exec_top.sv
// Extended instruction executor with Wishbone register access
module eie_exec_top #(
    parameter int DMEM_AW = eie_pkg::DMEM_AW,
    parameter int PMEM_AW = eie_pkg::PMEM_AW
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Wishbone slave
    input eie_pkg::eie_wb_req_t wbReq,
    output eie_pkg::eie_wb_rsp_t wbRsp,
    // Execution status
    output logic execBusy
);
    import eie_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rstSync_q;
    logic rstnInt;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rstSync_q <= 2'b00;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstnInt = rstSync_q[1];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_EXEC = 3'b001,
        ST_TABLE = 3'b010,
        ST_DUMMY1 = 3'b011,
        ST_DUMMY2 = 3'b100
    } eie_state_t;

    eie_state_t state_q, state_d;
    eie_cmd_t cmd_q, cmd_d;
    eie_flags_t flags_q, flags_d;
    logic [7:0] work_q, work_d;
    logic [7:0] tpl_q, tpl_d;
    logic [7:0] tph_q, tph_d;
    logic [7:0] tlatch_q, tlatch_d;
    logic [7:0] daddr_q, daddr_d;
    logic [PMEM_AW-1:0] paddr_q, paddr_d;
    logic skip_q, skip_d;
    logic [1:0] lastCyc_q, lastCyc_d;
    eie_wb_rsp_t rsp_q, rsp_d;
    logic busy_q, busy_d;

    // ------------------------------------------------------------
    // Memories and datapath
    // ------------------------------------------------------------
    logic [7:0] dmem [0:(1<<DMEM_AW)-1];
    logic dmemWe;
    logic [DMEM_AW-1:0] dmemWa;
    logic [7:0] dmemWd;
    logic [7:0] memByte;
    logic [7:0] busByte;
    logic [7:0] diff, xorVal, swapVal;
    eie_flags_t subFlags;
    logic [PMEM_AW-1:0] tableAddr;
    logic [15:0] tableWord;
    logic [15:0] busWord;
    logic pmemWe;

    assign memByte = dmem[cmd_q.addr[DMEM_AW-1:0]];
    assign busByte = dmem[daddr_q[DMEM_AW-1:0]];

    always_ff @(posedge clock) begin
        if (dmemWe) begin
            dmem[dmemWa] <= dmemWd;
        end
    end

    eie_alu uAlu (
        .working(work_q),
        .memByte(memByte),
        .diff(diff),
        .subFlags(subFlags),
        .xorVal(xorVal),
        .swapVal(swapVal)
    );

    // Last page is all ones above the low pointer
    wire isFinalPage = (cmd_q.op == OP_FINAL_PAGE_TABLE_FETCH) ||
                       (cmd_q.op == OP_PREINC_FINAL_PAGE_TABLE_FETCH);
    wire [PMEM_AW-1:0] finalAddr = {{(PMEM_AW-8){1'b1}}, tpl_q};
    wire [PMEM_AW-1:0] pagedAddr = {tph_q[PMEM_AW-9:0], tpl_q};
    assign tableAddr = isFinalPage ? finalAddr : pagedAddr;

    eie_prog_mem #(.AW(PMEM_AW), .DW(PWORD_W)) uPmem (
        .clock(clock),
        .we(pmemWe),
        .wa(paddr_q),
        .wd(wbReq.dat[15:0]),
        .raA(tableAddr),
        .rdA(tableWord),
        .raB(paddr_q),
        .rdB(busWord)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction : mergeBytes

    wire busReq = wbReq.cyc & wbReq.stb;
    // Writes land on the edge where the master sees ack
    wire wrTake = busReq & wbReq.we & rsp_q.ack;
    wire hitCmd = wbReq.adr == OFS_CMD;
    wire hitStat = wbReq.adr == OFS_STAT;
    wire hitWork = wbReq.adr == OFS_WORK;
    wire hitFlags = wbReq.adr == OFS_FLAGS;
    wire hitTpl = wbReq.adr == OFS_TPL;
    wire hitTph = wbReq.adr == OFS_TPH;
    wire hitTlatch = wbReq.adr == OFS_TLATCH;
    wire hitDaddr = wbReq.adr == OFS_DADDR;
    wire hitDdata = wbReq.adr == OFS_DDATA;
    wire hitPaddr = wbReq.adr == OFS_PADDR;
    wire hitPdata = wbReq.adr == OFS_PDATA;
    // State registers refuse bus writes while an instruction runs
    wire wrIdle = wrTake & (state_q == ST_IDLE);
    assign pmemWe = wrIdle & hitPdata;

    logic [31:0] readData;
    logic [31:0] statWord;
    logic [31:0] cmdMerged;
    assign statWord = {28'h0, lastCyc_q, skip_q, busy_q};
    assign cmdMerged = mergeBytes({17'h0, cmd_q}, wbReq.dat, wbReq.sel);

    always_comb begin
        readData = 32'h0000_0000;
        if (hitCmd) readData = {17'h0, cmd_q};
        if (hitStat) readData = statWord;
        if (hitWork) readData = {24'h0, work_q};
        if (hitFlags) readData = {26'h0, flags_q};
        if (hitTpl) readData = {24'h0, tpl_q};
        if (hitTph) readData = {24'h0, tph_q};
        if (hitTlatch) readData = {24'h0, tlatch_q};
        if (hitDaddr) readData = {24'h0, daddr_q};
        if (hitDdata) readData = {24'h0, busByte};
        if (hitPaddr) readData = {{(32-PMEM_AW){1'b0}}, paddr_q};
        if (hitPdata) readData = {16'h0, busWord};
    end

    always_comb begin
        rsp_d.ack = busReq & ~rsp_q.ack;
        rsp_d.dat = (busReq & ~rsp_q.ack) ? readData : rsp_q.dat;
    end

    // ------------------------------------------------------------
    // Execution
    // ------------------------------------------------------------
    wire isSkipOp = (cmd_q.op == OP_SKIP_WHEN_NULL) ||
                    (cmd_q.op == OP_SKIP_WHEN_NULL_WITH_MOVE) ||
                    (cmd_q.op == OP_SKIP_WHEN_BIT_CLEAR);
    wire isTableOp = (cmd_q.op == OP_PAGED_TABLE_FETCH) || isFinalPage ||
                     (cmd_q.op == OP_PREINC_PAGED_TABLE_FETCH);
    wire isPreinc = (cmd_q.op == OP_PREINC_PAGED_TABLE_FETCH) ||
                    (cmd_q.op == OP_PREINC_FINAL_PAGE_TABLE_FETCH);
    wire byteNull = (memByte == 8'h00);
    wire bitClear = ~memByte[cmd_q.bitSel];
    wire skipHit = (cmd_q.op == OP_SKIP_WHEN_BIT_CLEAR) ? bitClear : byteNull;

    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        flags_d = flags_q;
        work_d = work_q;
        tpl_d = tpl_q;
        tph_d = tph_q;
        tlatch_d = tlatch_q;
        daddr_d = daddr_q;
        paddr_d = paddr_q;
        skip_d = skip_q;
        lastCyc_d = lastCyc_q;
        dmemWe = 1'b0;
        dmemWa = cmd_q.addr[DMEM_AW-1:0];
        dmemWd = memByte;
        case (state_q)
            ST_IDLE: begin
                if (wrIdle & hitWork) work_d = wbReq.sel[0] ? wbReq.dat[7:0] :
                    work_q;
                if (wrIdle & hitFlags) flags_d = wbReq.sel[0] ? wbReq.dat[5:0] :
                    flags_q;
                if (wrIdle & hitTpl) tpl_d = wbReq.sel[0] ? wbReq.dat[7:0] : tpl_q;
                if (wrIdle & hitTph) tph_d = wbReq.sel[0] ? wbReq.dat[7:0] : tph_q;
                if (wrIdle & hitDaddr) daddr_d = wbReq.sel[0] ? wbReq.dat[7:0] : daddr_q;
                if (wrIdle & hitPaddr) paddr_d = PMEM_AW'(mergeBytes(
                    {{(32-PMEM_AW){1'b0}}, paddr_q}, wbReq.dat, wbReq.sel));
                if (wrIdle & hitDdata & wbReq.sel[0]) begin
                    dmemWe = 1'b1;
                    dmemWa = daddr_q[DMEM_AW-1:0];
                    dmemWd = wbReq.dat[7:0];
                end
                if (wrIdle & hitCmd) begin
                    cmd_d = cmdMerged[14:0];
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                skip_d = 1'b0;
                lastCyc_d = PLAIN_CYCLES;
                state_d = ST_IDLE;
                case (cmd_q.op)
                    OP_SUBTRACT_INTO_MEMORY: begin
                        dmemWe = 1'b1;
                        dmemWd = diff;
                        flags_d = subFlags;
                    end
                    OP_NIBBLE_EXCHANGE_INPLACE: begin
                        dmemWe = 1'b1;
                        dmemWd = swapVal;
                    end
                    OP_NIBBLE_EXCHANGE_TO_WORKING: begin
                        work_d = swapVal;
                    end
                    OP_SKIP_WHEN_NULL: begin
                        dmemWe = 1'b1;
                        dmemWd = memByte;
                    end
                    OP_SKIP_WHEN_NULL_WITH_MOVE: begin
                        work_d = memByte;
                    end
                    OP_EXCLUSIVE_OR_TO_WORKING: begin
                        work_d = xorVal;
                        flags_d.zero = (xorVal == 8'h00);
                    end
                    OP_EXCLUSIVE_OR_TO_MEMORY: begin
                        dmemWe = 1'b1;
                        dmemWd = xorVal;
                        flags_d.zero = (xorVal == 8'h00);
                    end
                    default: begin
                    end
                endcase
                if (isTableOp) begin
                    // Pointer settles before the word is addressed
                    if (isPreinc) tpl_d = tpl_q + 8'h01;
                    state_d = ST_TABLE;
                end
                if (isSkipOp && skipHit) begin
                    skip_d = 1'b1;
                    state_d = ST_DUMMY1;
                end
            end
            ST_TABLE: begin
                dmemWe = 1'b1;
                dmemWd = tableWord[7:0];
                tlatch_d = tableWord[15:8];
                lastCyc_d = TABLE_CYCLES;
                state_d = ST_IDLE;
            end
            ST_DUMMY1: begin
                // Dummy cycle stands in for the skipped fetch
                state_d = ST_DUMMY2;
            end
            ST_DUMMY2: begin
                lastCyc_d = SKIP_CYCLES;
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    assign busy_d = (state_d != ST_IDLE);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstnInt) begin
        if (!rstnInt) begin
            state_q <= ST_IDLE;
            cmd_q <= '0;
            flags_q <= FLAGS_RST;
            work_q <= WORK_RST;
            tpl_q <= TP_RST;
            tph_q <= TP_RST;
            tlatch_q <= TP_RST;
            daddr_q <= TP_RST;
            paddr_q <= PADDR_RST[PMEM_AW-1:0];
            skip_q <= 1'b0;
            lastCyc_q <= 2'h0;
            rsp_q <= '0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            flags_q <= flags_d;
            work_q <= work_d;
            tpl_q <= tpl_d;
            tph_q <= tph_d;
            tlatch_q <= tlatch_d;
            daddr_q <= daddr_d;
            paddr_q <= paddr_d;
            skip_q <= skip_d;
            lastCyc_q <= lastCyc_d;
            rsp_q <= rsp_d;
            busy_q <= busy_d;
        end
    end

    assign wbRsp = rsp_q;
    assign execBusy = busy_q;

endmodule : eie_exec_top

// ===== verification/eie_exec_sva.sv
// Bus and execution timing checker for the extended instruction executor
module eie_exec_sva (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Watched ports
    input eie_pkg::eie_wb_req_t wbReq,
    input eie_pkg::eie_wb_rsp_t wbRsp,
    input wire logic execBusy
);
    import eie_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic reqOn;
    logic rdAck;
    logic cmdGo;
    assign reqOn = wbReq.cyc && wbReq.stb;
    assign rdAck = wbRsp.ack && !wbReq.we;
    assign cmdGo = wbRsp.ack && wbReq.we && wbReq.adr == OFS_CMD && !execBusy;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_ack_follows_req: assert property (reqOn && !wbRsp.ack |=> wbRsp.ack)
        else $error("ack missing one cycle after request");
    chk_ack_one_pulse: assert property (wbRsp.ack |=> !wbRsp.ack)
        else $error("ack longer than one cycle");
    chk_ack_needs_req: assert property (!reqOn |=> !wbRsp.ack)
        else $error("ack without request");
    chk_cmd_starts_busy: assert property (cmdGo |=> execBusy)
        else $error("busy did not follow command");
    chk_busy_has_cause: assert property ($rose(execBusy) |-> $past(cmdGo))
        else $error("busy rose without command");
    chk_busy_max_three: assert property ($rose(execBusy) |-> ##[1:3] !execBusy)
        else $error("instruction ran over three cycles");
    chk_stat_width: assert property (rdAck && wbReq.adr == OFS_STAT |-> wbRsp.dat[31:4] == '0)
        else $error("status upper bits set");
    chk_byte_width: assert property (rdAck && (wbReq.adr == OFS_WORK || wbReq.adr == OFS_TPL
        || wbReq.adr == OFS_TLATCH || wbReq.adr == OFS_DDATA) |-> wbRsp.dat[31:8] == '0)
        else $error("byte register wider than 8 bits");
    chk_word_width: assert property (rdAck && wbReq.adr == OFS_PDATA |-> wbRsp.dat[31:16] == '0)
        else $error("program word wider than 16 bits");
    chk_flags_width: assert property (rdAck && wbReq.adr == OFS_FLAGS |-> wbRsp.dat[31:6] == '0)
        else $error("flag register wider than 6 bits");
    chk_unmapped_zero: assert property (rdAck && wbReq.adr > OFS_PDATA |-> wbRsp.dat == '0)
        else $error("unmapped read not zero");

endmodule : eie_exec_sva

bind eie_exec_top eie_exec_sva u_sva (
    .clock(clock),
    .rstn(rstn),
    .wbReq(wbReq),
    .wbRsp(wbRsp),
    .execBusy(execBusy)
);

// ===== verification/eie_exec_top_tb.sv
// Self-checking bench: random operands per opcode against an integer model
module eie_exec_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import eie_pkg::*;

    logic clock;
    logic rstn;
    eie_wb_req_t wbReq;
    eie_wb_rsp_t wbRsp;
    logic execBusy;
    int fails = 0;
    int samplesChecked = 0;

    eie_exec_top dut (.clock(clock), .rstn(rstn), .wbReq(wbReq), .wbRsp(wbRsp),
        .execBusy(execBusy));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Closing, comparison and bus tasks
    // ------------------------------------------------------------
    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samplesChecked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Classic cycle; entered just after a rising edge
    task xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        n = 0;
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: ad, dat: wd};
        do begin
            @(posedge clock);
            n++;
        end while (wbRsp.ack !== 1'b1 && n < 32);
        rd = wbRsp.dat;
        wbReq <= '0;
        @(posedge clock);
        if (n >= 32) begin
            fails++;
            print_verdict();
        end
    endtask : xfer

    task wr(input logic [7:0] ad, input int v);
        logic [31:0] d;
        xfer(1'b1, ad, 32'(v), d);
    endtask : wr

    task rdChk(input logic [7:0] ad, input int v, input string what);
        logic [31:0] d;
        xfer(1'b0, ad, 32'h0, d);
        check(d, 32'(v), what);
    endtask : rdChk

    task waitIdle;
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            xfer(1'b0, OFS_STAT, 32'h0, s);
            n++;
        end while (s[0] !== 1'b0 && n < 20);
        if (n >= 20) begin
            fails++;
            print_verdict();
        end
    endtask : waitIdle

    function automatic int swapN(input int v);
        return ((v % 16) * 16) + (v / 16);
    endfunction : swapN

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge clock);
        fails++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int w, m, a, b, tl, th, fl, pw, ntl, r, vf, z;
        int em, ew, ef, sk, cy, tlat;
        rstn = 1'b0;
        wbReq = '0;
        tlat = 0;
        void'($urandom(32'hA42D));
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        rdChk(OFS_WORK, 0, "work reset");
        rdChk(OFS_FLAGS, 0, "flags reset");
        rdChk(OFS_TPL, 0, "pointer low reset");
        rdChk(OFS_STAT, 0, "status reset");
        wr(OFS_TLATCH, 32'h5A);
        rdChk(OFS_TLATCH, 0, "latch read only");
        rdChk(8'h40, 0, "unmapped read");
        $display("Test reset and map done");
        for (int op = 0; op < 16; op++) begin
            for (int i = 0; i < 4; i++) begin
                w = $urandom % 256;
                a = $urandom % 256;
                b = $urandom % 8;
                th = $urandom % 16;
                fl = $urandom % 64;
                pw = $urandom % 65536;
                m = (i == 0) ? 0 : (i == 1) ? w : $urandom % 256;
                tl = (i == 2) ? 255 : $urandom % 256;
                ntl = (op == 8 || op == 9) ? (tl + 1) % 256 : tl;
                wr(OFS_WORK, w);
                wr(OFS_FLAGS, fl);
                wr(OFS_TPL, tl);
                wr(OFS_TPH, th);
                wr(OFS_DADDR, a);
                wr(OFS_DDATA, m);
                wr(OFS_PADDR, ((op == 6 || op == 8) ? th : 15) * 256 + ntl);
                wr(OFS_PDATA, pw);
                em = m;
                ew = w;
                ef = fl;
                sk = 0;
                cy = 1;
                r = (w - m) & 255;
                vf = ((w ^ m) & (w ^ r) & 128) != 0;
                z = ((w ^ m) == 0);
                case (op)
                    0: begin
                        em = r;
                        ef = (w >= m) + ((w % 16) >= (m % 16)) * 2 + (r == 0) * 4 + vf * 8
                            + (vf ^ (r / 128)) * 16 + (r == 0) * 32;
                    end
                    1: em = swapN(m);
                    2: ew = swapN(m);
                    3: sk = (m == 0);
                    4: begin
                        ew = m;
                        sk = (m == 0);
                    end
                    5: sk = ((m >> b) & 1) == 0;
                    10: begin
                        ew = w ^ m;
                        ef = (fl & 32'h3B) + z * 4;
                    end
                    11: begin
                        em = w ^ m;
                        ef = (fl & 32'h3B) + z * 4;
                    end
                    // Undefined codes run one cycle and change nothing
                    12, 13, 14, 15: begin
                    end
                    default: begin
                        em = pw % 256;
                        tlat = pw / 256;
                        cy = 2;
                    end
                endcase
                if (sk != 0)
                    cy = 3;
                wr(OFS_CMD, b * 4096 + a * 16 + op);
                // A taken skip is still busy here, so this write must be refused
                if (sk != 0)
                    wr(OFS_WORK, 255 - ew);
                waitIdle();
                rdChk(OFS_STAT, sk * 2 + cy * 4, "status");
                rdChk(OFS_WORK, ew, "working");
                rdChk(OFS_FLAGS, ef, "flags");
                rdChk(OFS_TPL, ntl, "pointer low");
                rdChk(OFS_TLATCH, tlat, "table latch");
                rdChk(OFS_DDATA, em, "memory byte");
            end
            $display("Test opcode %0d done", op);
        end
        print_verdict();
    end

endmodule : eie_exec_top_tb
